// *** core/retry_ctrl_pkg.sv ***
// Shared constants, types and decode helpers for the retry and arbiter control
package retry_ctrl_pkg;

	// ------------------------------------------------------------------
	// Bus widths
	// ------------------------------------------------------------------
	localparam int ADDR_W  = 12;               // Register byte address width
	localparam int DATA_W  = 32;               // Register data width
	localparam int CODE_W  = 4;                // Retry limit code width
	localparam int COUNT_W = 32;               // Retry counter width (2G fits)
	localparam int EVENT_W = 2;                // Interrupt event count

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_RETRY_LIMIT = 12'h040;
	localparam logic [ADDR_W-1:0] OFS_MISC_CTRL   = 12'h044;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS  = 12'h048;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR   = 12'h04C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE  = 12'h050;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int BIT_ARB_ENABLE  = 30;       // Internal arbitration enable
	localparam int BIT_PARITY_MODE = 24;       // Parity error behaviour
	localparam int EV_EXPIRED      = 0;        // Request expired event
	localparam int EV_PARITY       = 1;        // Write data parity event

	localparam logic [CODE_W-1:0]  RST_RETRY_CODE  = 4'h0;
	localparam logic               RST_ARB_ENABLE  = 1'b1;
	localparam logic               PARITY_MODE     = 1'b1; // Read-only value
	localparam logic [EVENT_W-1:0] RST_EVENTS      = 2'h0;
	localparam logic [DATA_W-1:0]  ZERO_WORD       = 32'h0000_0000;
	localparam logic [COUNT_W-1:0] ZERO_COUNT      = 32'h0000_0000;
	localparam logic [COUNT_W-1:0] ONE_COUNT       = 32'h0000_0001;

	// ------------------------------------------------------------------
	// One-hot retry limit codes and their retry counts
	// ------------------------------------------------------------------
	localparam logic [CODE_W-1:0]  CODE_256 = 4'h1;
	localparam logic [CODE_W-1:0]  CODE_64K = 4'h2;
	localparam logic [CODE_W-1:0]  CODE_16M = 4'h4;
	localparam logic [CODE_W-1:0]  CODE_2G  = 4'h8;
	localparam logic [COUNT_W-1:0] LIMIT_256 = 32'h0000_0100;
	localparam logic [COUNT_W-1:0] LIMIT_64K = 32'h0001_0000;
	localparam logic [COUNT_W-1:0] LIMIT_16M = 32'h0100_0000;
	localparam logic [COUNT_W-1:0] LIMIT_2G  = 32'h8000_0000;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;               // Byte address
		logic [DATA_W-1:0] wdata;              // Write data
		logic              wr;                 // Write strobe
		logic              rd;                 // Read strobe
	} reg_req_t;

	// Zero means no expiration; codes other than one-hot also never expire
	function automatic logic [COUNT_W-1:0] limit_of(
		input logic [CODE_W-1:0] code);
		logic [COUNT_W-1:0] lim;
		lim = ZERO_COUNT;
		case (code)
			CODE_256: lim = LIMIT_256;
			CODE_64K: lim = LIMIT_64K;
			CODE_16M: lim = LIMIT_16M;
			CODE_2G:  lim = LIMIT_2G;
			default:  lim = ZERO_COUNT;
		endcase
		return lim;
	endfunction

endpackage

// *** core/retry_counter.sv ***
// Per-request retry counter that expires at the selected limit
`timescale 1ns/1ns
module retry_counter
	import retry_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               resetn,
	// Request tracking
	input  wire logic               req_start,
	input  wire logic               retry_seen,
	input  wire logic               req_done,
	input  wire logic [COUNT_W-1:0] limit,
	// State out
	output logic                    active,
	output logic [COUNT_W-1:0]      count,
	output logic                    expired
);

	// ------------------------------------------------------------------
	// Next-state decode
	// ------------------------------------------------------------------
	wire logic [COUNT_W-1:0] next_count  = count + ONE_COUNT;  // Count-up
	wire logic               limit_on    = (limit != ZERO_COUNT);
	wire logic               take_retry  = active && retry_seen;
	// Expire on the retry that makes the count reach the limit
	wire logic               next_expire = take_retry && limit_on &&
		(next_count == limit);

	// ------------------------------------------------------------------
	// Counter state
	// ------------------------------------------------------------------
	// A new request wins over anything else in the same cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			active  <= 1'b0;
			count   <= ZERO_COUNT;
			expired <= 1'b0;
		end else if (req_start) begin          // Fresh request, count from 0
			active  <= 1'b1;
			count   <= ZERO_COUNT;
			expired <= 1'b0;
		end else begin
			expired <= next_expire;
			if (next_expire || req_done)
				active <= 1'b0;
			if (take_retry)
				count <= next_count;
		end
	end

endmodule // retry_counter

// *** core/secondary_retry_arbiter_ctrl.sv ***
// Retry limiting, arbitration enable and parity behaviour register bank
//
// Behaviour
// - Count secondary retries, compare against 4-bit limit
// - At limit, abandon request and stop reissuing
// - Limit code zero never expires a request
// - One-hot codes select 256, 64K, 16M, 2G
`timescale 1ns/1ns
module secondary_retry_arbiter_ctrl
	import retry_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              resetn,
	// Register port
	input  wire reg_req_t          reg_req,
	output logic [DATA_W-1:0]      reg_rdata,
	// Forwarded request tracking
	input  wire logic              req_start,
	input  wire logic              retry_seen,
	input  wire logic              req_done,
	output logic                   request_discard,
	output logic                   request_active,
	// Arbitration
	input  wire logic              internal_req,
	output logic                   arb_request,
	// Non-posted write parity handling
	input  wire logic              write_parity_err,
	output logic                   parity_error_pin_n,
	output logic                   data_pass,
	output logic                   data_discard,
	output logic                   origin_error,
	output logic                   status_set,
	// Interrupt
	output logic                   irq
);

	// ------------------------------------------------------------------
	// Software-visible state
	// ------------------------------------------------------------------
	logic [CODE_W-1:0]  retry_limit_code;      // Retry limit selector
	logic               arb_enable;            // Internal arbitration enable
	logic [EVENT_W-1:0] irq_status;            // Sticky event bits
	logic [EVENT_W-1:0] irq_enable;            // Event enables

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	wire logic hit_limit  = (reg_req.addr == OFS_RETRY_LIMIT);
	wire logic hit_misc   = (reg_req.addr == OFS_MISC_CTRL);
	wire logic hit_status = (reg_req.addr == OFS_IRQ_STATUS);
	wire logic hit_enable = (reg_req.addr == OFS_IRQ_ENABLE);
	wire logic hit_clear  = (reg_req.addr == OFS_IRQ_CLEAR);

	// Word images; reserved bits read as zero
	wire logic [DATA_W-1:0] limit_word = {{(DATA_W-CODE_W){1'b0}},
		retry_limit_code};
	wire logic [DATA_W-1:0] misc_word  = ZERO_WORD |
		(DATA_W'(arb_enable) << BIT_ARB_ENABLE) |
		(DATA_W'(PARITY_MODE) << BIT_PARITY_MODE);
	wire logic [DATA_W-1:0] status_word = {{(DATA_W-EVENT_W){1'b0}},
		irq_status};
	wire logic [DATA_W-1:0] enable_word = {{(DATA_W-EVENT_W){1'b0}},
		irq_enable};

	// Clear register is write-only and reads zero, like unmapped space
	wire logic [DATA_W-1:0] read_mux =
		hit_limit  ? limit_word  :
		hit_misc   ? misc_word   :
		hit_status ? status_word :
		hit_enable ? enable_word : ZERO_WORD;

	wire logic [EVENT_W-1:0] clear_bits = (reg_req.wr && hit_clear) ?
		reg_req.wdata[EVENT_W-1:0] : RST_EVENTS;

	// ------------------------------------------------------------------
	// Register writes and read data
	// ------------------------------------------------------------------
	// Read data stand only in the cycle after the read strobe
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= ZERO_WORD;
		end else begin
			reg_rdata <= reg_req.rd ? read_mux : ZERO_WORD;
		end
	end

	// Control writes; the parity mode bit is read-only and ignores writes
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			retry_limit_code <= RST_RETRY_CODE;
			arb_enable       <= RST_ARB_ENABLE;
			irq_enable       <= RST_EVENTS;
		end else if (reg_req.wr) begin
			if (hit_limit)
				retry_limit_code <= reg_req.wdata[CODE_W-1:0];
			if (hit_misc)
				arb_enable <= reg_req.wdata[BIT_ARB_ENABLE];
			if (hit_enable)
				irq_enable <= reg_req.wdata[EVENT_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// Retry counting
	// ------------------------------------------------------------------
	wire logic [COUNT_W-1:0] retry_limit = limit_of(retry_limit_code);
	logic [COUNT_W-1:0]      retry_count;  // Retries seen on this request

	retry_counter u_counter (
		.clock      (clock),
		.resetn     (resetn),
		.req_start  (req_start),
		.retry_seen (retry_seen),
		.req_done   (req_done),
		.limit      (retry_limit),
		.active     (request_active),
		.count      (retry_count),
		.expired    (request_discard)
	);

	// ------------------------------------------------------------------
	// Arbitration gate and parity handling
	// ------------------------------------------------------------------
	// Registered gate keeps the request output glitch free
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			arb_request        <= 1'b0;
			parity_error_pin_n <= 1'b1;
			data_pass          <= 1'b0;
			data_discard       <= 1'b0;
			origin_error       <= 1'b0;
			status_set         <= 1'b0;
		end else begin
			arb_request        <= internal_req && arb_enable;
			parity_error_pin_n <= !write_parity_err;
			data_pass    <= write_parity_err && !PARITY_MODE;
			data_discard <= write_parity_err && PARITY_MODE;
			origin_error <= write_parity_err && PARITY_MODE;
			status_set   <= write_parity_err && PARITY_MODE;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------------
	wire logic [EVENT_W-1:0] events = {write_parity_err, request_discard};

	// A new event in the clearing cycle wins over the clear
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			irq_status <= RST_EVENTS;
			irq        <= 1'b0;
		end else begin
			irq_status <= (irq_status & ~clear_bits) | events;
			irq        <= |(((irq_status & ~clear_bits) | events) &
				irq_enable);
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence s_retry_taken;
		request_active && retry_seen && !req_start;
	endsequence

	property p_count_step;
		s_retry_taken ##0 !request_discard |=> (retry_count ==
			$past(retry_count) + ONE_COUNT) || request_discard;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("Retry count did not advance");

	property p_discard_ends;
		request_discard |-> !request_active ##1 !request_discard;
	endproperty
	a_discard_ends: assert property (p_discard_ends)
		else $error("Request still active after discard");

	property p_no_expire_zero;
		(retry_limit_code == RST_RETRY_CODE) ##1
			(retry_limit_code == RST_RETRY_CODE) |-> !request_discard;
	endproperty
	a_no_expire_zero: assert property (p_no_expire_zero)
		else $error("Request expired with limit code zero");

	property p_limit_reached;
		request_discard && !$past(req_start) |->
			$past(retry_count) + ONE_COUNT == limit_of($past(retry_limit_code));
	endproperty
	a_limit_reached: assert property (p_limit_reached)
		else $error("Discard not at selected retry limit");

	property p_arb_gate;
		internal_req && arb_enable |=> arb_request;
	endproperty
	a_arb_gate: assert property (p_arb_gate)
		else $error("Enabled internal request missing");

	property p_arb_block;
		!arb_enable |=> !arb_request;
	endproperty
	a_arb_block: assert property (p_arb_block)
		else $error("Disabled internal request reached arbitration");

	sequence s_parity_reply;
		!parity_error_pin_n && data_discard && origin_error && status_set &&
			!data_pass;
	endsequence

	property p_parity;
		write_parity_err |=> s_parity_reply;
	endproperty
	a_parity: assert property (p_parity)
		else $error("Parity error handling wrong");

	property p_irq_level;
		irq_status[EV_EXPIRED] && irq_enable[EV_EXPIRED] && !reg_req.wr
			|=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("Interrupt not raised for enabled status");

endmodule // secondary_retry_arbiter_ctrl

// *** test/retry_target_model.sv ***
// Secondary-bus target model that answers forwarded requests with retries
`timescale 1ns/1ns
module retry_target_model (
	// Clock and reset
	input  wire logic clock,
	input  wire logic resetn,
	// Request view and pacing
	input  wire logic active,
	input  wire logic slow,
	// Retry termination pulse
	output logic      retry_seen
);
	logic phase; // Alternates each cycle for slow pacing

	// A busy target retries every attempt; slow mode answers every other
	// cycle, so the bridge must not assume one retry per clock
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			phase      <= 1'b0;
			retry_seen <= 1'b0;
		end else begin
			phase      <= ~phase;
			retry_seen <= active & (~slow | phase);
		end
	end
endmodule // retry_target_model

// *** test/secondary_retry_arbiter_ctrl_tb_top.sv ***
// Self-checking testbench for the retry and arbiter control bank
`timescale 1ns/1ns
module secondary_retry_arbiter_ctrl_tb_top
	import retry_ctrl_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic              clock, resetn;            // Clock and reset
	reg_req_t          req;                      // Register request
	logic [DATA_W-1:0] rdata;                    // Register read data
	logic              req_start, req_done;      // Request framing
	logic              retry_seen, slow;         // Target retries, pacing
	logic              request_discard;          // Expiry pulse
	logic              request_active;           // Tracking level
	logic              internal_req, arb_request; // Arbitration
	logic              write_parity_err;         // Parity event
	logic              pin_n, dpass, ddisc;      // Parity outputs
	logic              origin, stat, irq;        // Reporting outputs
	int                miscompares, check_count; // Result counters
	logic [DATA_W-1:0] v;                        // Discard samples ORed together

	secondary_retry_arbiter_ctrl dut_u (.clock(clock), .resetn(resetn),
		.reg_req(req), .reg_rdata(rdata), .req_start(req_start),
		.retry_seen(retry_seen), .req_done(req_done),
		.request_discard(request_discard), .request_active(request_active),
		.internal_req(internal_req), .arb_request(arb_request),
		.write_parity_err(write_parity_err), .parity_error_pin_n(pin_n),
		.data_pass(dpass), .data_discard(ddisc), .origin_error(origin),
		.status_set(stat), .irq(irq));
	retry_target_model target_u (.clock(clock), .resetn(resetn),
		.active(request_active), .slow(slow), .retry_seen(retry_seen));

	// Free-running 25 MHz clock
	always #20 clock = ~clock;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Single-cycle write strobe
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		req <= '0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rchk(input string what, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] e);
		@(posedge clock);
		req <= '{addr: a, wdata: ZERO_WORD, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		req <= '0;
		#1 chk(what, rdata, e);
	endtask

	// Retries taken up to and including the discard edge equal the limit
	task automatic expire(input logic [3:0] code, input int lim,
		input logic pace);
		int   n;
		int   k;
		logic prev;
		n = 0;
		prev = 1'b0;
		wr(OFS_RETRY_LIMIT, 32'(code));
		slow <= pace;
		@(posedge clock);
		req_start <= 1'b1;
		@(posedge clock);
		req_start <= 1'b0;
		for (k = 0; k < 3 * lim + 8; k++) begin
			#1;
			// The retry taken at the discard edge still counts
			if (prev) n++;
			if (request_discard === 1'b1) break;
			prev = retry_seen & request_active;
			@(posedge clock);
		end
		chk("discard", request_discard, 32'h0000_0001);
		chk("retries", 32'(n), 32'(lim));
		chk("active", request_active, ZERO_WORD);
		@(posedge clock);
		#1 chk("discard end", request_discard, ZERO_WORD);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		req = '0;
		{req_start, req_done, internal_req, write_parity_err, slow} = '0;
		miscompares = 0;
		check_count = 0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		rchk("limit reset", OFS_RETRY_LIMIT, ZERO_WORD);
		rchk("misc reset", OFS_MISC_CTRL, 32'h4100_0000);
		wr(OFS_RETRY_LIMIT, 32'hFFFF_FFF8);
		rchk("limit field", OFS_RETRY_LIMIT, 32'h0000_0008);
		rchk("unmapped", 12'h07C, ZERO_WORD);
		@(posedge clock);
		internal_req <= 1'b1;
		repeat (2) @(posedge clock);
		#1 chk("arb on", arb_request, 32'h0000_0001);
		wr(OFS_MISC_CTRL, ZERO_WORD);
		@(posedge clock);
		#1 chk("arb off", arb_request, ZERO_WORD);
		rchk("mode ro", OFS_MISC_CTRL, 32'h0100_0000);
		$display("test registers and arbitration done");
		// Parity event with its interrupt enabled
		wr(OFS_IRQ_ENABLE, 32'h0000_0003);
		@(posedge clock);
		write_parity_err <= 1'b1;
		@(posedge clock);
		write_parity_err <= 1'b0;
		#1 chk("parity", {pin_n, dpass, ddisc, origin, stat, irq},
			32'h0000_000F);
		@(posedge clock);
		#1 chk("pin idle", pin_n, 32'h0000_0001);
		rchk("status par", OFS_IRQ_STATUS, 32'h0000_0002);
		wr(OFS_IRQ_CLEAR, 32'h0000_0002);
		rchk("status clr", OFS_IRQ_STATUS, ZERO_WORD);
		chk("irq clr", irq, ZERO_WORD);
		$display("test parity done");
		// Expiry with prompt and slow targets, then the 64K limit
		expire(CODE_256, LIMIT_256, 1'b0);
		expire(CODE_256, LIMIT_256, 1'b1);
		rchk("status exp", OFS_IRQ_STATUS, 32'h0000_0001);
		chk("irq exp", irq, 32'h0000_0001);
		wr(OFS_IRQ_CLEAR, 32'h0000_0001);
		expire(CODE_64K, LIMIT_64K, 1'b0);
		$display("test expiry done");
		// Code zero keeps retrying well past the smallest limit
		wr(OFS_RETRY_LIMIT, ZERO_WORD);
		@(posedge clock);
		req_start <= 1'b1;
		@(posedge clock);
		req_start <= 1'b0;
		v = ZERO_WORD;
		repeat (600) begin
			@(posedge clock);
			#1 v = v | 32'(request_discard);
		end
		chk("no expiry", v, ZERO_WORD);
		chk("still active", request_active, 32'h0000_0001);
		@(posedge clock);
		req_done <= 1'b1;
		@(posedge clock);
		req_done <= 1'b0;
		@(posedge clock);
		#1 chk("done", request_active, ZERO_WORD);
		$display("test no expiry done");
		end_sim();
	end

	// Watchdog sized well above the longest expiry run
	initial begin
		#(40 * 90_000);
		miscompares++;
		end_sim();
	end
endmodule // secondary_retry_arbiter_ctrl_tb_top
